// ==== verilog/ofh_pkg.sv ====
// constants for the 1394 function configuration header tail
package ofh_pkg;
  localparam int          OFH_ADDR_W       = 8;
  localparam int          OFH_DATA_W       = 32;
  localparam int          OFH_BE_W         = 4;
  // byte offsets of the dwords in configuration space
  localparam logic [7:0]  OFH_OFF_CARD_BASE = 8'h18;
  localparam logic [7:0]  OFH_OFF_CARD_PTR  = 8'h28;
  localparam logic [7:0]  OFH_OFF_SUBSYS_ID = 8'h2c;
  localparam logic [7:0]  OFH_OFF_PWR_PTR   = 8'h34;
  localparam logic [7:0]  OFH_OFF_IRQ_LINE  = 8'h3c;
  localparam logic [7:0]  OFH_OFF_PM_REG0   = 8'h44;
  localparam logic [7:0]  OFH_OFF_PM_REG1   = 8'h48;
  localparam logic [7:0]  OFH_OFF_SUBSYS_AC = 8'hf8;
  // field positions
  localparam int          OFH_DEV_CODE_LSB  = 16;
  localparam int          OFH_VEND_CODE_LSB = 0;
  localparam int          OFH_CODE_W        = 16;
  localparam int          OFH_IRQ_LINE_W    = 8;
  // reset and fixed values
  localparam logic [31:0] OFH_ZERO_WORD     = 32'h0000_0000;
  localparam logic [31:0] OFH_SUBSYS_RST    = 32'h0000_0000;
  localparam logic [7:0]  OFH_PWR_PTR_VAL   = 8'h44;
  localparam logic [7:0]  OFH_IRQ_LINE_RST  = 8'h00;
  localparam int          OFH_SYNC_STAGES   = 2;
endpackage

// ==== verilog/ofh_subsys_store.sv ====
// subsystem identity holder, kept across function resets
`timescale 1ns/1ps
module ofh_subsys_store
  import ofh_pkg::*;
(
  input  wire logic                  i_clock,       // configuration clock
  input  wire logic                  i_global_reset_input_n,      // synchronised global reset
  input  wire logic                  i_load_vld,    // eeprom load strobe
  input  wire logic [OFH_DATA_W-1:0] i_load_data,   // eeprom identity word
  input  wire logic                  i_wr,          // access register write strobe
  input  wire logic [OFH_BE_W-1:0]   i_wr_be,       // write byte enables
  input  wire logic [OFH_DATA_W-1:0] i_wr_data,     // write data
  output logic      [OFH_DATA_W-1:0] o_subsys_id    // device code high, vendor low
);
  typedef struct packed {
    logic [OFH_DATA_W-1:0] subsys_id;
  } ofh_store_s;

  ofh_store_s state_r;
  ofh_store_s state_nxt;

  always_comb
  begin
    state_nxt = state_r;
    // eeprom load wins over a software write in the same cycle
    if (i_load_vld)
    begin
      state_nxt.subsys_id = i_load_data;
    end
    else if (i_wr)
    begin
      for (int b = 0; b < OFH_BE_W; b++)
      begin
        if (i_wr_be[b])
        begin
          state_nxt.subsys_id[b*8 +: 8] = i_wr_data[b*8 +: 8];
        end
      end
    end
  end

  // only the global reset reaches this flop
  always_ff @(posedge i_clock or negedge i_global_reset_input_n)
  begin
    if (!i_global_reset_input_n)
    begin
      state_r <= '{subsys_id: OFH_SUBSYS_RST};
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign o_subsys_id = state_r.subsys_id;

  property p_load_takes;
    @(posedge i_clock) disable iff (!i_global_reset_input_n)
    i_load_vld |=> (o_subsys_id == $past(i_load_data));
  endproperty
  a_load_takes: assert property (p_load_takes) else $error("eeprom load not taken");

  property p_full_write;
    @(posedge i_clock) disable iff (!i_global_reset_input_n)
    (i_wr && !i_load_vld && (i_wr_be == 4'hf)) |=> (o_subsys_id == $past(i_wr_data));
  endproperty
  a_full_write: assert property (p_full_write) else $error("access write not taken");
endmodule

// ==== verilog/ofh_cfg_tail.sv ====
// configuration header tail: card info, subsystem identity, power pointer, interrupt line
`timescale 1ns/1ps
module ofh_cfg_tail
  import ofh_pkg::*;
#(
  parameter int ADDR_W = OFH_ADDR_W,                        // config space byte address width
  parameter int DATA_W = OFH_DATA_W                         // config data width
)
(
  input  wire logic              i_clock,          // configuration clock, 200 MHz
  input  wire logic              i_rst_n,          // function reset, active low
  input  wire logic              i_global_rst_n,   // global reset input, active low
  input  wire logic              i_cfg_req,        // configuration cycle request
  input  wire logic              i_cfg_we,         // 1 write, 0 read
  input  wire logic [ADDR_W-1:0] i_cfg_addr,       // byte address, low two bits ignored
  input  wire logic [3:0]        i_cfg_be,         // byte enables
  input  wire logic [DATA_W-1:0] i_cfg_wdata,      // write data
  output logic                   o_cfg_ack,        // answer pulse
  output logic      [DATA_W-1:0] o_cfg_rdata,      // read data, valid with ack
  input  wire logic              i_eeprom_vld,     // eeprom identity load strobe
  input  wire logic [DATA_W-1:0] i_eeprom_ssid,    // eeprom identity word
  input  wire logic [DATA_W-1:0] i_pm_rdata0,      // power register word at 44h
  input  wire logic [DATA_W-1:0] i_pm_rdata1,      // power register word at 48h
  output logic                   o_pm_wr,          // power register write pulse
  output logic                   o_pm_sel,         // 0 word 44h, 1 word 48h
  output logic      [3:0]        o_pm_be,          // power register byte enables
  output logic      [DATA_W-1:0] o_pm_wdata,       // power register write data
  output logic      [7:0]        o_irq_route_line, // stored interrupt routing line
  output logic      [DATA_W-1:0] o_subsys_id       // subsystem identity
);
  if (ADDR_W != OFH_ADDR_W || DATA_W != OFH_DATA_W)
  begin : g_bad_width
    $error("ofh_cfg_tail serves only an 8-bit address and 32-bit data");
  end

  typedef struct packed {
    logic                     ack;
    logic [OFH_DATA_W-1:0]    rdata;
    logic [OFH_IRQ_LINE_W-1:0] irq_line;
    logic                     pm_wr;
    logic                     pm_sel;
    logic [OFH_BE_W-1:0]      pm_be;
    logic [OFH_DATA_W-1:0]    pm_wdata;
  } ofh_top_s;

  ofh_top_s                        state_r;
  ofh_top_s                        state_nxt;
  logic [OFH_SYNC_STAGES-1:0]      frst_sync_r;
  logic [OFH_SYNC_STAGES-1:0]      global_reset_input_sync_r;
  logic                            frst_n;
  logic                            global_reset_input_n;
  logic                            rst_raw_n;
  logic                            id_wr;
  logic [OFH_DATA_W-1:0]           subsys_id;

  function automatic logic hit(input logic [OFH_ADDR_W-1:0] addr, input logic [7:0] off);
    hit = (addr[OFH_ADDR_W-1:2] == off[7:2]);
  endfunction

  // global reset also resets the function side
  assign rst_raw_n = i_rst_n & i_global_rst_n;

  always_ff @(posedge i_clock or negedge rst_raw_n)
  begin
    if (!rst_raw_n)
    begin
      frst_sync_r <= '0;
    end
    else
    begin
      frst_sync_r <= {frst_sync_r[0], 1'b1};
    end
  end

  always_ff @(posedge i_clock or negedge i_global_rst_n)
  begin
    if (!i_global_rst_n)
    begin
      global_reset_input_sync_r <= '0;
    end
    else
    begin
      global_reset_input_sync_r <= {global_reset_input_sync_r[0], 1'b1};
    end
  end

  assign frst_n = frst_sync_r[1];
  assign global_reset_input_n = global_reset_input_sync_r[1];

  // requests during function reset are dropped, so only an eeprom load can move the identity then
  assign id_wr = frst_n && i_cfg_req && i_cfg_we && hit(i_cfg_addr, OFH_OFF_SUBSYS_AC);

  ofh_subsys_store u_store (
    .i_clock     (i_clock),
    .i_global_reset_input_n    (global_reset_input_n),
    .i_load_vld  (i_eeprom_vld),
    .i_load_data (i_eeprom_ssid),
    .i_wr        (id_wr),
    .i_wr_be     (i_cfg_be),
    .i_wr_data   (i_cfg_wdata),
    .o_subsys_id (subsys_id)
  );

  always_comb
  begin
    state_nxt       = state_r;
    state_nxt.ack   = 1'b0;
    state_nxt.pm_wr = 1'b0;
    if (i_cfg_req)
    begin
      state_nxt.ack   = 1'b1;
      state_nxt.rdata = OFH_ZERO_WORD;
      if (i_cfg_we)
      begin
        // read-only targets simply absorb the write
        if (hit(i_cfg_addr, OFH_OFF_IRQ_LINE) && i_cfg_be[0])
        begin
          state_nxt.irq_line = i_cfg_wdata[OFH_IRQ_LINE_W-1:0];
        end
        if (hit(i_cfg_addr, OFH_OFF_PM_REG0) || hit(i_cfg_addr, OFH_OFF_PM_REG1))
        begin
          state_nxt.pm_wr    = 1'b1;
          state_nxt.pm_sel   = hit(i_cfg_addr, OFH_OFF_PM_REG1);
          state_nxt.pm_be    = i_cfg_be;
          state_nxt.pm_wdata = i_cfg_wdata;
        end
      end
      else
      begin
        if (hit(i_cfg_addr, OFH_OFF_CARD_BASE) || hit(i_cfg_addr, OFH_OFF_CARD_PTR))
        begin
          state_nxt.rdata = OFH_ZERO_WORD;
        end
        else if (hit(i_cfg_addr, OFH_OFF_SUBSYS_ID))
        begin
          state_nxt.rdata[OFH_DEV_CODE_LSB +: OFH_CODE_W]  = subsys_id[OFH_DEV_CODE_LSB +: OFH_CODE_W];
          state_nxt.rdata[OFH_VEND_CODE_LSB +: OFH_CODE_W] = subsys_id[OFH_VEND_CODE_LSB +: OFH_CODE_W];
        end
        else if (hit(i_cfg_addr, OFH_OFF_PWR_PTR))
        begin
          state_nxt.rdata[7:0] = OFH_PWR_PTR_VAL;
        end
        else if (hit(i_cfg_addr, OFH_OFF_IRQ_LINE))
        begin
          state_nxt.rdata[OFH_IRQ_LINE_W-1:0] = state_r.irq_line;
        end
        else if (hit(i_cfg_addr, OFH_OFF_PM_REG0))
        begin
          state_nxt.rdata = i_pm_rdata0;
        end
        else if (hit(i_cfg_addr, OFH_OFF_PM_REG1))
        begin
          state_nxt.rdata = i_pm_rdata1;
        end
      end
    end
  end

  always_ff @(posedge i_clock or negedge frst_n)
  begin
    if (!frst_n)
    begin
      state_r <= '{ack: 1'b0, rdata: OFH_ZERO_WORD, irq_line: OFH_IRQ_LINE_RST, pm_wr: 1'b0,
                   pm_sel: 1'b0, pm_be: 4'h0, pm_wdata: OFH_ZERO_WORD};
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign o_cfg_ack        = state_r.ack;
  assign o_cfg_rdata      = state_r.rdata;
  assign o_pm_wr          = state_r.pm_wr;
  assign o_pm_sel         = state_r.pm_sel;
  assign o_pm_be          = state_r.pm_be;
  assign o_pm_wdata       = state_r.pm_wdata;
  assign o_irq_route_line = state_r.irq_line;
  assign o_subsys_id      = subsys_id;

  property p_card_zero;
    @(posedge i_clock) disable iff (!frst_n)
    (i_cfg_req && !i_cfg_we && (hit(i_cfg_addr, OFH_OFF_CARD_BASE) || hit(i_cfg_addr, OFH_OFF_CARD_PTR)))
      |=> (o_cfg_ack && o_cfg_rdata == 32'h0000_0000);
  endproperty
  a_card_zero: assert property (p_card_zero) else $error("card info register not zero");

  property p_id_fields;
    @(posedge i_clock) disable iff (!frst_n)
    (i_cfg_req && !i_cfg_we && hit(i_cfg_addr, OFH_OFF_SUBSYS_ID))
      |=> (o_cfg_rdata[31:16] == $past(subsys_id[31:16]) && o_cfg_rdata[15:0] == $past(subsys_id[15:0]));
  endproperty
  a_id_fields: assert property (p_id_fields) else $error("identity fields misplaced");

  property p_id_kept;
    @(posedge i_clock) disable iff (!global_reset_input_n)
    (!frst_n && !i_eeprom_vld) |=> $stable(o_subsys_id);
  endproperty
  a_id_kept: assert property (p_id_kept) else $error("identity moved in function reset");

  property p_pwr_ptr;
    @(posedge i_clock) disable iff (!frst_n)
    (i_cfg_req && !i_cfg_we && hit(i_cfg_addr, OFH_OFF_PWR_PTR)) |=> (o_cfg_rdata == 32'h0000_0044);
  endproperty
  a_pwr_ptr: assert property (p_pwr_ptr) else $error("power pointer not 44h");

  property p_pm_read;
    @(posedge i_clock) disable iff (!frst_n)
    (i_cfg_req && !i_cfg_we && hit(i_cfg_addr, OFH_OFF_PM_REG1))
      |=> (o_cfg_ack && o_cfg_rdata == $past(i_pm_rdata1));
  endproperty
  a_pm_read: assert property (p_pm_read) else $error("power word 48h not routed");

  property p_irq_write;
    @(posedge i_clock) disable iff (!frst_n)
    (i_cfg_req && i_cfg_we && hit(i_cfg_addr, OFH_OFF_IRQ_LINE) && i_cfg_be[0])
      |=> (o_irq_route_line == $past(i_cfg_wdata[7:0]))
          ##1 ($stable(o_irq_route_line) || $past(i_cfg_req && i_cfg_we && hit(i_cfg_addr, OFH_OFF_IRQ_LINE)));
  endproperty
  a_irq_write: assert property (p_irq_write) else $error("interrupt line write lost");

  property p_ro_write;
    @(posedge i_clock) disable iff (!frst_n)
    (i_cfg_req && i_cfg_we && !i_eeprom_vld && (hit(i_cfg_addr, OFH_OFF_SUBSYS_ID) ||
      hit(i_cfg_addr, OFH_OFF_PWR_PTR) || hit(i_cfg_addr, OFH_OFF_CARD_BASE)))
      |=> (o_cfg_ack && $stable(o_subsys_id) && $stable(o_irq_route_line));
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only write had an effect");

  property p_ack_once;
    @(posedge i_clock) disable iff (!frst_n)
    i_cfg_req |=> o_cfg_ack;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("request not answered");
endmodule

// ==== test/ofh_host_model.sv ====
// configuration host model issuing single dword cycles
`timescale 1ns/1ps
module ofh_host_model
  import ofh_pkg::*;
(
  input  wire logic                  i_clock, // config clock
  output logic                       o_req,   // request pulse
  output logic                       o_we,    // write select
  output logic      [OFH_ADDR_W-1:0] o_addr,  // byte address
  output logic      [OFH_BE_W-1:0]   o_be,    // byte enables
  output logic      [OFH_DATA_W-1:0] o_wdata, // write data
  input  wire logic                  i_ack,   // answer pulse
  input  wire logic [OFH_DATA_W-1:0] i_rdata  // read data
);
  initial
  begin
    o_req = 1'b0;
    o_we = 1'b0;
    o_addr = 8'h00;
    o_be = 4'h0;
    o_wdata = 32'h0000_0000;
  end
  // one-cycle request; answer taken in the cycle it stands
  task automatic cfg(input logic w, input logic [7:0] a, input logic [3:0] b,
                     input logic [31:0] d, output logic [31:0] r, output logic ok);
    int n;
    ok = 1'b0;
    r = 32'h0000_0000;
    @(negedge i_clock);
    o_req = 1'b1;
    o_we = w;
    o_addr = a;
    o_be = b;
    o_wdata = d;
    @(negedge i_clock);
    o_req = 1'b0;
    // released lines show the inverse so a stale value cannot pass
    o_addr = ~a;
    o_be = ~b;
    o_wdata = ~d;
    for (n = 0; n < 4 && ok !== 1'b1; n++)
    begin
      if (i_ack === 1'b1)
      begin
        ok = 1'b1;
        r = i_rdata;
      end
      else
        @(negedge i_clock);
    end
  endtask
endmodule

// ==== test/tb_ofh_cfg_tail.sv ====
// self-checking bench for the configuration header tail
`timescale 1ns/1ps
module tb_ofh_cfg_tail;
  import ofh_pkg::*;
  logic clk, rst_n, global_reset_input_n, req, we, ack, ev, pwr, psel;
  logic [7:0] addr, irq;
  logic [3:0] be, pbe;
  logic [31:0] wd, rd, ed, p0, p1, pwd, sid, r;
  int n_errors = 0;
  int compares = 0;
  ofh_cfg_tail u_dut (.i_clock(clk), .i_rst_n(rst_n), .i_global_rst_n(global_reset_input_n),
    .i_cfg_req(req), .i_cfg_we(we), .i_cfg_addr(addr), .i_cfg_be(be), .i_cfg_wdata(wd),
    .o_cfg_ack(ack), .o_cfg_rdata(rd), .i_eeprom_vld(ev), .i_eeprom_ssid(ed),
    .i_pm_rdata0(p0), .i_pm_rdata1(p1), .o_pm_wr(pwr), .o_pm_sel(psel), .o_pm_be(pbe),
    .o_pm_wdata(pwd), .o_irq_route_line(irq), .o_subsys_id(sid));
  ofh_host_model u_host (.i_clock(clk), .o_req(req), .o_we(we), .o_addr(addr), .o_be(be),
    .o_wdata(wd), .i_ack(ack), .i_rdata(rd));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] b,
                     input logic [31:0] d, output logic [31:0] q);
    logic ok;
    u_host.cfg(w, a, b, d, q, ok);
    chk({31'h0, ok}, 32'h0000_0001, "answer");
    if (ok !== 1'b1)
      results();
  endtask
  task automatic do_reset(input logic gl);
    @(negedge clk);
    rst_n = 1'b0;
    global_reset_input_n = ~gl;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    global_reset_input_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask
  logic [7:0] ta [6] = '{8'h18, 8'h28, 8'h2c, 8'h34, 8'h3c, 8'h40};
  logic [31:0] te [6] = '{32'h0, 32'h0, 32'h0, {24'h0, OFH_PWR_PTR_VAL}, 32'h0, 32'h0};
  task automatic t_defaults();
    for (int i = 0; i < 6; i++)
    begin
      acc(1'b0, ta[i], 4'hf, 32'h0, r);
      chk(r, te[i], "reset value");
    end
    $display("test defaults done");
  endtask
  task automatic t_ro_writes();
    for (int i = 0; i < 4; i++)
    begin
      acc(1'b1, ta[i], 4'hf, 32'hffff_ffff, r);
      acc(1'b0, ta[i], 4'hf, 32'h0, r);
      chk(r, te[i], "read-only after write");
    end
    $display("test ro_writes done");
  endtask
  task automatic t_irq_line();
    acc(1'b1, 8'h3c, 4'h1, 32'h1234_56a5, r);
    chk({24'h0, irq}, 32'h0000_00a5, "line out");
    acc(1'b1, 8'h3c, 4'he, 32'hffff_ff5a, r);
    acc(1'b0, 8'h3c, 4'hf, 32'h0, r);
    chk(r, 32'h0000_00a5, "line read");
    $display("test irq_line done");
  endtask
  task automatic t_subsys();
    acc(1'b1, OFH_OFF_SUBSYS_AC, 4'hf, 32'h1234_abcd, r);
    chk(sid, 32'h1234_abcd, "identity out");
    acc(1'b0, OFH_OFF_SUBSYS_ID, 4'hf, 32'h0, r);
    chk({16'h0, r[31:16]}, 32'h0000_1234, "device code");
    chk({16'h0, r[15:0]}, 32'h0000_abcd, "vendor code");
    acc(1'b0, OFH_OFF_SUBSYS_AC, 4'hf, 32'h0, r);
    chk(r, 32'h0, "access reg read");
    // load and access write taken at one edge: the load is kept
    fork
      acc(1'b1, OFH_OFF_SUBSYS_AC, 4'hf, 32'h0bad_0bad, r);
      begin
        @(negedge clk);
        ev = 1'b1;
        ed = 32'h7e81_18e7;
        @(negedge clk);
        ev = 1'b0;
        ed = 32'h0;
      end
    join
    chk(sid, 32'h7e81_18e7, "load beats write");
    @(negedge clk);
    ev = 1'b1;
    ed = 32'h5a5a_c3c3;
    @(negedge clk);
    ev = 1'b0;
    ed = 32'ha5a5_3c3c;
    acc(1'b0, OFH_OFF_SUBSYS_ID, 4'hf, 32'h0, r);
    chk(r, 32'h5a5a_c3c3, "eeprom load");
    acc(1'b1, OFH_OFF_SUBSYS_AC, 4'h1, 32'h0000_00ff, r);
    acc(1'b0, OFH_OFF_SUBSYS_ID, 4'hf, 32'h0, r);
    chk(r, 32'h5a5a_c3ff, "byte write");
    $display("test subsys done");
  endtask
  task automatic t_pm();
    acc(1'b0, OFH_OFF_PM_REG0, 4'hf, 32'h0, r);
    chk(r, 32'h1111_2222, "pm word 0");
    acc(1'b0, OFH_OFF_PM_REG1, 4'hf, 32'h0, r);
    chk(r, 32'h3333_4444, "pm word 1");
    acc(1'b1, OFH_OFF_PM_REG1, 4'h3, 32'hcafe_0001, r);
    chk({28'h0, pwr, psel, 2'h0}, 32'h0000_000c, "pm strobe");
    chk({28'h0, pbe}, 32'h0000_0003, "pm be");
    chk(pwd, 32'hcafe_0001, "pm data");
    @(negedge clk);
    chk({30'h0, ack, pwr}, 32'h0, "pulses end");
    chk({28'h0, pbe}, 32'h0000_0003, "pm be stands");
    acc(1'b1, OFH_OFF_PM_REG0, 4'hc, 32'h0000_beef, r);
    chk({28'h0, pwr, psel, pbe[3:2]}, 32'h0000_000b, "pm word 0 strobe");
    acc(1'b1, OFH_OFF_IRQ_LINE, 4'h0, 32'h0, r);
    chk({31'h0, pwr}, 32'h0, "no pm strobe");
    $display("test pm done");
  endtask
  task automatic t_resets();
    do_reset(1'b0);
    chk({24'h0, irq}, 32'h0, "line after reset");
    acc(1'b0, OFH_OFF_SUBSYS_ID, 4'hf, 32'h0, r);
    chk(r, 32'h5a5a_c3ff, "identity kept");
    do_reset(1'b1);
    acc(1'b0, OFH_OFF_SUBSYS_ID, 4'hf, 32'h0, r);
    chk(r, OFH_SUBSYS_RST, "identity cleared");
    $display("test resets done");
  endtask
  initial
  begin
    rst_n = 1'b0;
    global_reset_input_n = 1'b0;
    ev = 1'b0;
    ed = 32'h0;
    p0 = 32'h1111_2222;
    p1 = 32'h3333_4444;
    do_reset(1'b1);
    t_defaults();
    t_ro_writes();
    t_irq_line();
    t_subsys();
    t_pm();
    t_resets();
    results();
  end
endmodule
